// ### sfs_host.sv
module sfs_host (
  input  wire logic                       clk,
  input  wire logic [sfs_pkg::DATA_W-1:0] rdata,
  input  wire logic                       rvalid,
  output sfs_pkg::sfs_reg_req_t           req
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ok;
  initial begin
    req = '0;
    ok  = 1'b1;
  end
  // A clear names only the channels whose bits are one, so others are never disturbed.
  task automatic write(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(negedge clk);
    req.wr = 1'b0;
  endtask
  task automatic read(input logic [7:0] addr, output logic [7:0] data);
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
    @(negedge clk);
    req.rd = 1'b0;
    ok     = (rvalid === 1'b1);
    data   = rdata;
  endtask
endmodule

// ### sfs_monitor.sv
// Contract
// - Summary bit 7 ORs power-up order faults.
// - Flag rail when power-up log differs expected.
// - Summary bit 6 ORs power-down order faults.
// - Flag rail when power-down log differs expected.
// - Summary bit 5 ORs wake order faults.
// - Flag rail when wake log differs expected.
// - Summary bit 4 ORs doze order faults.
// - Flag rail when doze log differs expected.
// - Summary bit 3 ORs slow overvoltage flags.
// - Summary bit 2 ORs fast overvoltage flags.
// - Summary bit 1 ORs slow undervoltage flags.
// - Summary bit 0 ORs fast undervoltage flags.
// - Summary is read-only, derived from detail bits.
// - Fast undervoltage bit sets below channel threshold while its enable is set.
// - Recovery alone never clears fast undervoltage bit.
// - Clear works only once voltage recovered.
// - Disabled channel bit reads zero.
// - Global source bit 0 ORs summary.
// - Interrupt line low only when source nonzero.
module sfs_monitor (
  input  wire logic                          CLK,
  input  wire logic                          RESET,
  input  wire sfs_pkg::sfs_reg_req_t         REG_REQ,
  input  wire sfs_pkg::sfs_seq_in_t          SEQ_ORDERS,
  input  wire sfs_pkg::sfs_volt_flags_t      CHANNEL_FLAGS,
  input  wire logic [sfs_pkg::NUM_CH-1:0]    FAST_UV_BELOW,
  input  wire logic [sfs_pkg::NUM_CH-1:0]    FAST_UV_IRQ_ENABLE,
  output logic      [sfs_pkg::DATA_W-1:0]    REG_RDATA,
  output logic                               REG_RVALID,
  output logic      [sfs_pkg::DATA_W-1:0]    FAULT_SUMMARY,
  output logic                               INTERRUPT_OUT_LOW_OUT,
  output logic                               INTERRUPT_OUT_LOW_OE
);

  typedef struct packed {
    logic [sfs_pkg::DATA_W-1:0] rdata;
    logic                       rvalid;
    logic [sfs_pkg::DATA_W-1:0] summary;
    logic                       pin_level;
    logic                       pin_drive;
  } sfs_mon_state_t;

  sfs_mon_state_t state_q;
  sfs_mon_state_t state_d;

  logic [sfs_pkg::NUM_CH-1:0] up_detail;
  logic [sfs_pkg::NUM_CH-1:0] down_detail;
  logic [sfs_pkg::NUM_CH-1:0] wake_detail;
  logic [sfs_pkg::NUM_CH-1:0] doze_detail;
  logic [sfs_pkg::NUM_CH-1:0] fast_uv_flags;
  logic [sfs_pkg::DATA_W-1:0] summary;
  logic [sfs_pkg::DATA_W-1:0] global_source;
  logic                       fast_uv_clear;

  // Aligns a per-channel detail register into an 8-bit read word.
  function automatic logic [sfs_pkg::DATA_W-1:0] chan_word(input logic [sfs_pkg::NUM_CH-1:0] bits);
    chan_word = {{(sfs_pkg::DATA_W - sfs_pkg::NUM_CH){1'b0}}, bits};
  endfunction

  function automatic logic is_write(input sfs_pkg::sfs_reg_req_t req, input logic [7:0] addr);
    is_write = req.wr && (req.addr == addr);
  endfunction

  sfs_order_check u_power_up (
    .clk      (CLK),
    .reset    (RESET),
    .orders   (SEQ_ORDERS.power_up),
    .mismatch (up_detail)
  );

  sfs_order_check u_power_down (
    .clk      (CLK),
    .reset    (RESET),
    .orders   (SEQ_ORDERS.power_down),
    .mismatch (down_detail)
  );

  sfs_order_check u_wake (
    .clk      (CLK),
    .reset    (RESET),
    .orders   (SEQ_ORDERS.wake),
    .mismatch (wake_detail)
  );

  sfs_order_check u_doze (
    .clk      (CLK),
    .reset    (RESET),
    .orders   (SEQ_ORDERS.doze),
    .mismatch (doze_detail)
  );

  // Only a write to the fast undervoltage address reaches the flags; a write
  // to the summary or global source address decodes to nothing.
  assign fast_uv_clear = is_write(REG_REQ, sfs_pkg::ADDR_FAST_UV_FLAGS);

  sfs_uv_flags u_fast_uv (
    .clk        (CLK),
    .reset      (RESET),
    .below      (FAST_UV_BELOW),
    .enable     (FAST_UV_IRQ_ENABLE),
    .clear_wr   (fast_uv_clear),
    .clear_mask (REG_REQ.wdata[sfs_pkg::NUM_CH-1:0]),
    .flags      (fast_uv_flags)
  );

  always_comb begin
    summary = '0;
    summary[sfs_pkg::SUM_POWER_UP_BIT]   = |up_detail;
    summary[sfs_pkg::SUM_POWER_DOWN_BIT] = |down_detail;
    summary[sfs_pkg::SUM_WAKE_BIT]       = |wake_detail;
    summary[sfs_pkg::SUM_DOZE_BIT]       = |doze_detail;
    summary[sfs_pkg::SUM_SLOW_OV_BIT]    = |CHANNEL_FLAGS.slow_ov;
    summary[sfs_pkg::SUM_FAST_OV_BIT]    = |CHANNEL_FLAGS.fast_ov;
    summary[sfs_pkg::SUM_SLOW_UV_BIT]    = |CHANNEL_FLAGS.slow_uv;
    summary[sfs_pkg::SUM_FAST_UV_BIT]    = |fast_uv_flags;
  end

  // Other interrupt causes live outside this block and read as zero here.
  always_comb begin
    global_source = '0;
    global_source[sfs_pkg::SRC_MONITOR_BIT] = |summary;
  end

  always_comb begin
    state_d           = state_q;
    state_d.rvalid    = REG_REQ.rd;
    state_d.summary   = summary;
    state_d.pin_drive = global_source != '0;
    state_d.pin_level = !(global_source != '0);
    if (REG_REQ.rd) begin
      unique case (REG_REQ.addr)
        sfs_pkg::ADDR_GLOBAL_SOURCE: state_d.rdata = global_source;
        sfs_pkg::ADDR_MONITOR_SUM:   state_d.rdata = summary;
        sfs_pkg::ADDR_FAST_UV_FLAGS: state_d.rdata = chan_word(fast_uv_flags);
        default:                     state_d.rdata = sfs_pkg::DATA_RESET;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      state_q.rdata     <= sfs_pkg::DATA_RESET;
      state_q.rvalid    <= 1'b0;
      state_q.summary   <= sfs_pkg::DATA_RESET;
      state_q.pin_level <= 1'b1;
      state_q.pin_drive <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  assign REG_RDATA             = state_q.rdata;
  assign REG_RVALID            = state_q.rvalid;
  assign FAULT_SUMMARY         = state_q.summary;
  assign INTERRUPT_OUT_LOW_OUT = state_q.pin_level;
  assign INTERRUPT_OUT_LOW_OE  = state_q.pin_drive;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  sequence s_read_summary;
    REG_REQ.rd && (REG_REQ.addr == sfs_pkg::ADDR_MONITOR_SUM);
  endsequence

  sequence s_read_fast_uv;
    REG_REQ.rd && (REG_REQ.addr == sfs_pkg::ADDR_FAST_UV_FLAGS);
  endsequence

  sequence s_read_source;
    REG_REQ.rd && (REG_REQ.addr == sfs_pkg::ADDR_GLOBAL_SOURCE);
  endsequence

  sequence s_write_summary;
    REG_REQ.wr && (REG_REQ.addr == sfs_pkg::ADDR_MONITOR_SUM);
  endsequence

  sequence s_write_source;
    REG_REQ.wr && (REG_REQ.addr == sfs_pkg::ADDR_GLOBAL_SOURCE);
  endsequence

  sequence s_write_fast_uv;
    REG_REQ.wr && (REG_REQ.addr == sfs_pkg::ADDR_FAST_UV_FLAGS);
  endsequence

  sequence s_up_mismatch;
    SEQ_ORDERS.power_up.logged != SEQ_ORDERS.power_up.expected;
  endsequence

  sequence s_down_mismatch;
    SEQ_ORDERS.power_down.logged != SEQ_ORDERS.power_down.expected;
  endsequence

  sequence s_wake_mismatch;
    SEQ_ORDERS.wake.logged != SEQ_ORDERS.wake.expected;
  endsequence

  sequence s_doze_mismatch;
    SEQ_ORDERS.doze.logged != SEQ_ORDERS.doze.expected;
  endsequence

  // A trip only reaches the pin if its enable still stands when the flag is
  // first read out; a dropped enable masks the sticky bit again at once.
  sequence s_fast_uv_trip;
    ((FAST_UV_BELOW & FAST_UV_IRQ_ENABLE) != '0) ##1 $stable(FAST_UV_IRQ_ENABLE);
  endsequence

  a_up_order_read: assert property (
    s_read_summary |=> REG_RVALID && (REG_RDATA[7] == $past(|up_detail)))
    else $error("Summary bit 7 does not match power-up detail.");

  a_seq_bits_read: assert property (
    s_read_summary |=> (REG_RDATA[6:4] == {$past(|down_detail), $past(|wake_detail), $past(|doze_detail)}))
    else $error("Summary sequence bits do not match detail.");

  a_volt_bits_read: assert property (
    s_read_summary |=> (REG_RDATA[3:0] == {$past(|CHANNEL_FLAGS.slow_ov), $past(|CHANNEL_FLAGS.fast_ov),
                                           $past(|CHANNEL_FLAGS.slow_uv), $past(|fast_uv_flags)}))
    else $error("Summary voltage bits do not match detail.");

  a_summary_tracks: assert property (
    FAULT_SUMMARY[0] == $past(|fast_uv_flags))
    else $error("Summary copy lags or leads its detail.");

  // Write checks allow for an enable that moves under them, because the
  // enable masks the read-out without touching the sticky bits behind it.
  a_summary_no_write: assert property (
    (s_write_summary and (FAST_UV_BELOW == '0))
      |=> (!$stable(FAST_UV_IRQ_ENABLE) || (fast_uv_flags == $past(fast_uv_flags))))
    else $error("Write to summary changed a fault bit.");

  a_source_no_write: assert property (
    (s_write_source and (FAST_UV_BELOW == '0))
      |=> (!$stable(FAST_UV_IRQ_ENABLE) || (fast_uv_flags == $past(fast_uv_flags))))
    else $error("Write to the global source changed a fault bit.");

  a_zero_write_keeps: assert property (
    (s_write_fast_uv and (REG_REQ.wdata[sfs_pkg::NUM_CH-1:0] == '0))
      |=> (!$stable(FAST_UV_IRQ_ENABLE) || ((fast_uv_flags & $past(fast_uv_flags)) == $past(fast_uv_flags))))
    else $error("Write of zeros cleared a fast undervoltage bit.");

  // Set wins over clear, so only channels that were not below may be expected clear.
  a_recovered_clear: assert property (
    s_write_fast_uv
      |=> ((fast_uv_flags & $past(REG_REQ.wdata[sfs_pkg::NUM_CH-1:0]) & ~$past(FAST_UV_BELOW)) == '0))
    else $error("Write of one did not clear a recovered channel.");

  a_reserved_zero: assert property (
    s_read_fast_uv |=> (REG_RDATA[7:6] == 2'h0) && (REG_RDATA[5:0] == $past(fast_uv_flags)))
    else $error("Fast undervoltage read is wrong.");

  a_source_monitor: assert property (
    s_read_source |=> (REG_RDATA == {7'h00, $past(|summary)}))
    else $error("Global source does not reflect the summary.");

  a_irq_follows: assert property (
    (global_source != '0) |=> INTERRUPT_OUT_LOW_OE && !INTERRUPT_OUT_LOW_OUT)
    else $error("Interrupt line not driven for a pending source.");

  a_irq_quiet: assert property (
    (global_source == '0) |=> !INTERRUPT_OUT_LOW_OE)
    else $error("Interrupt line driven with a clear source.");

  a_irq_release: assert property (
    (global_source == '0) |=> INTERRUPT_OUT_LOW_OUT)
    else $error("Interrupt pin level low with a clear source.");

  a_irq_pin_pair: assert property (
    INTERRUPT_OUT_LOW_OE != INTERRUPT_OUT_LOW_OUT)
    else $error("Interrupt pin drive and level disagree.");

  a_irq_has_cause: assert property (
    INTERRUPT_OUT_LOW_OE |-> $past(|summary))
    else $error("Interrupt line driven without a monitor cause.");

  // An order mismatch is registered in its checker on the first edge and
  // reaches the registered summary copy on the second.
  a_up_order_flag: assert property (
    s_up_mismatch |=> ##1 FAULT_SUMMARY[sfs_pkg::SUM_POWER_UP_BIT])
    else $error("Power-up order mismatch missing from the summary.");

  a_down_order_flag: assert property (
    s_down_mismatch |=> ##1 FAULT_SUMMARY[sfs_pkg::SUM_POWER_DOWN_BIT])
    else $error("Power-down order mismatch missing from the summary.");

  a_wake_order_flag: assert property (
    s_wake_mismatch |=> ##1 FAULT_SUMMARY[sfs_pkg::SUM_WAKE_BIT])
    else $error("Wake order mismatch missing from the summary.");

  a_doze_order_flag: assert property (
    s_doze_mismatch |=> ##1 FAULT_SUMMARY[sfs_pkg::SUM_DOZE_BIT])
    else $error("Doze order mismatch missing from the summary.");

  // The copy is compared from the second edge after reset only, since the
  // detail inputs from outside need not be quiet while reset is held.
  a_summary_copy: assert property (
    !$past(RESET) |-> (FAULT_SUMMARY == $past(summary)))
    else $error("Summary copy differs from the summary one edge earlier.");

  a_uv_trip_irq: assert property (
    s_fast_uv_trip |=> INTERRUPT_OUT_LOW_OE && FAULT_SUMMARY[sfs_pkg::SUM_FAST_UV_BIT])
    else $error("Fast undervoltage trip did not reach the pin.");

endmodule

// ### sfs_order_check.sv
module sfs_order_check (
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire sfs_pkg::sfs_order_set_t orders,
  output logic [sfs_pkg::NUM_CH-1:0]   mismatch
);

  typedef struct packed {
    logic [sfs_pkg::NUM_CH-1:0] mismatch;
  } sfs_oc_state_t;

  sfs_oc_state_t state_q;
  sfs_oc_state_t state_d;

  always_comb begin
    state_d = state_q;
    for (int i = 0; i < sfs_pkg::NUM_CH; i++) begin
      state_d.mismatch[i] = orders.logged[i] != orders.expected[i];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign mismatch = state_q.mismatch;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_order_mismatch_flag: assert property (
    (orders.logged[0] != orders.expected[0]) |=> mismatch[0])
    else $error("Rail 1 order mismatch was not flagged.");

  a_order_match_clear: assert property (
    (orders.logged == orders.expected) |=> (mismatch == '0))
    else $error("Matching orders still flag a fault.");

endmodule

// ### sfs_pkg.sv
package sfs_pkg;

  localparam int unsigned NUM_CH  = 6;
  localparam int unsigned ORDER_W = 8;
  localparam int unsigned DATA_W  = 8;

  // Register map of the monitor status block.
  localparam logic [7:0] ADDR_GLOBAL_SOURCE = 8'h10;
  localparam logic [7:0] ADDR_MONITOR_SUM   = 8'h11;
  localparam logic [7:0] ADDR_FAST_UV_FLAGS = 8'h12;

  // Bit positions in the monitor fault summary.
  localparam int unsigned SUM_POWER_UP_BIT   = 7;
  localparam int unsigned SUM_POWER_DOWN_BIT = 6;
  localparam int unsigned SUM_WAKE_BIT       = 5;
  localparam int unsigned SUM_DOZE_BIT       = 4;
  localparam int unsigned SUM_SLOW_OV_BIT    = 3;
  localparam int unsigned SUM_FAST_OV_BIT    = 2;
  localparam int unsigned SUM_SLOW_UV_BIT    = 1;
  localparam int unsigned SUM_FAST_UV_BIT    = 0;

  // Bit position of the monitor cause in the global source.
  localparam int unsigned SRC_MONITOR_BIT = 0;

  // Reset values; the hardware leaves them undefined, zero is used here.
  localparam logic [NUM_CH-1:0] FLAGS_RESET = 6'h00;
  localparam logic [DATA_W-1:0] DATA_RESET  = 8'h00;

  typedef struct packed {
    logic                        wr;
    logic                        rd;
    logic [7:0]                  addr;
    logic [DATA_W-1:0]           wdata;
  } sfs_reg_req_t;

  typedef struct packed {
    logic [NUM_CH-1:0][ORDER_W-1:0] logged;
    logic [NUM_CH-1:0][ORDER_W-1:0] expected;
  } sfs_order_set_t;

  typedef struct packed {
    sfs_order_set_t power_up;
    sfs_order_set_t power_down;
    sfs_order_set_t wake;
    sfs_order_set_t doze;
  } sfs_seq_in_t;

  typedef struct packed {
    logic [NUM_CH-1:0] slow_ov;
    logic [NUM_CH-1:0] fast_ov;
    logic [NUM_CH-1:0] slow_uv;
  } sfs_volt_flags_t;

endpackage

// ### sfs_uv_flags.sv
module sfs_uv_flags (
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire logic [sfs_pkg::NUM_CH-1:0] below,
  input  wire logic [sfs_pkg::NUM_CH-1:0] enable,
  input  wire logic                       clear_wr,
  input  wire logic [sfs_pkg::NUM_CH-1:0] clear_mask,
  output logic      [sfs_pkg::NUM_CH-1:0] flags
);

  typedef struct packed {
    logic [sfs_pkg::NUM_CH-1:0] raw;
  } sfs_uv_state_t;

  sfs_uv_state_t state_q;
  sfs_uv_state_t state_d;
  logic [sfs_pkg::NUM_CH-1:0] clr;

  // A clear only takes effect on channels that have recovered, so a clear
  // racing a new fault never loses it.
  always_comb begin
    state_d = state_q;
    clr     = clear_wr ? (clear_mask & ~below) : '0;
    state_d.raw = (state_q.raw & ~clr) | (below & enable);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q.raw <= sfs_pkg::FLAGS_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  assign flags = state_q.raw & enable;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_uv_sets_fault: assert property (
    ((below & enable) != '0) |=> ((state_q.raw & $past(below & enable)) == $past(below & enable)))
    else $error("Fast undervoltage bit did not set.");

  a_uv_stays_set: assert property (
    !clear_wr |=> ((state_q.raw & $past(state_q.raw)) == $past(state_q.raw)))
    else $error("Fast undervoltage bit cleared without a write.");

  a_uv_clear_guard: assert property (
    (clear_wr && ((clear_mask & below & state_q.raw) != '0))
      |=> ((state_q.raw & $past(clear_mask & below & state_q.raw)) != '0))
    else $error("Clear removed a bit while the fault persisted.");

  a_uv_masked_read: assert property (
    (flags & ~enable) == '0)
    else $error("Disabled channel reads as faulted.");

endmodule

// ### tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     clk;
  logic                     rst;
  sfs_pkg::sfs_reg_req_t    req;
  sfs_pkg::sfs_seq_in_t     seq;
  sfs_pkg::sfs_volt_flags_t vflags;
  logic [5:0]               below;
  logic [5:0]               uv_en;
  logic [7:0]               rdata;
  logic                     rvalid;
  logic [7:0]               fsum;
  logic                     irq_out;
  logic                     irq_oe;
  logic [31:0]              lfsr;
  logic [5:0]               uv_exp;
  int                       err_total;
  int                       tests_run;
  int                       cycles;

  sfs_monitor i_sfs_monitor (
    .CLK                   (clk),
    .RESET                 (rst),
    .REG_REQ               (req),
    .SEQ_ORDERS            (seq),
    .CHANNEL_FLAGS         (vflags),
    .FAST_UV_BELOW         (below),
    .FAST_UV_IRQ_ENABLE    (uv_en),
    .REG_RDATA             (rdata),
    .REG_RVALID            (rvalid),
    .FAULT_SUMMARY         (fsum),
    .INTERRUPT_OUT_LOW_OUT (irq_out),
    .INTERRUPT_OUT_LOW_OE  (irq_oe)
  );

  sfs_host i_sfs_host (
    .clk    (clk),
    .rdata  (rdata),
    .rvalid (rvalid),
    .req    (req)
  );

  function automatic logic [31:0] nxt();
    lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h0040_0007 : 32'h0000_0000);
    return lfsr;
  endfunction

  // Mismatches are rare so that the all-clear case of each kind is reached often.
  function automatic sfs_pkg::sfs_order_set_t mk_set(input logic [31:0] r);
    sfs_pkg::sfs_order_set_t o;
    o.logged   = {r, r[31:16]};
    o.expected = o.logged;
    if (r[1:0] == 2'b00) begin
      o.expected[r[18:16] % 6] = o.logged[r[18:16] % 6] ^ (r[15:8] | 8'h01);
    end
    return o;
  endfunction

  function automatic logic [7:0] sum_exp(input logic [5:0] uv);
    return {seq.power_up.logged != seq.power_up.expected, seq.power_down.logged != seq.power_down.expected,
            seq.wake.logged != seq.wake.expected, seq.doze.logged != seq.doze.expected,
            |vflags.slow_ov, |vflags.fast_ov, |vflags.slow_uv, |uv};
  endfunction

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic chk_pin(input logic [1:0] got, input logic [1:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %b expected %b", $time, msg, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] got;
    i_sfs_host.read(addr, got);
    chk_pin({1'b0, i_sfs_host.ok}, 2'b01, "read answer");
    chk_reg(got, exp, "read data");
  endtask

  task automatic settle_check();
    logic [7:0] e;
    repeat (3) @(negedge clk);
    e = sum_exp(uv_exp & uv_en);
    rd_chk(sfs_pkg::ADDR_MONITOR_SUM, e);
    rd_chk(sfs_pkg::ADDR_GLOBAL_SOURCE, {7'h00, |e});
    rd_chk(sfs_pkg::ADDR_FAST_UV_FLAGS, {2'b00, uv_exp & uv_en});
    chk_reg(fsum, e, "summary copy");
    chk_pin({irq_oe, irq_out}, (|e) ? 2'b10 : 2'b01, "interrupt pin");
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // The run needs about five hundred cycles, so the ceiling leaves ample margin.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      err_total++;
      conclude();
    end
  end

  initial begin
    err_total = 0;
    tests_run = 0;
    cycles    = 0;
    lfsr      = 32'h0000_5d73;
    uv_exp    = 6'h00;
    seq       = '0;
    vflags    = '0;
    below     = 6'h00;
    uv_en     = 6'h00;
    rst       = 1'b1;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    settle_check();
    rd_chk(8'h13, 8'h00);
    for (int i = 0; i < 40; i++) begin
      seq.power_up   = mk_set(nxt());
      seq.power_down = mk_set(nxt());
      seq.wake       = mk_set(nxt());
      seq.doze       = mk_set(nxt());
      vflags         = (i == 0) ? '1 : 18'(nxt() & nxt() & nxt());
      uv_en          = 6'(nxt());
      settle_check();
    end
    seq    = '0;
    vflags = '0;
    uv_en  = 6'h3f;
    below  = 6'h21;
    repeat (2) @(negedge clk);
    below  = 6'h00;
    uv_exp = 6'h21;
    settle_check();
    i_sfs_host.write(sfs_pkg::ADDR_FAST_UV_FLAGS, 8'h00);
    i_sfs_host.write(sfs_pkg::ADDR_MONITOR_SUM, 8'hff);
    i_sfs_host.write(sfs_pkg::ADDR_GLOBAL_SOURCE, 8'hff);
    settle_check();
    below = 6'h20;
    i_sfs_host.write(sfs_pkg::ADDR_FAST_UV_FLAGS, 8'hff);
    uv_exp = 6'h20;
    settle_check();
    below = 6'h00;
    uv_en = 6'h1f;
    settle_check();
    i_sfs_host.write(sfs_pkg::ADDR_FAST_UV_FLAGS, 8'hc0);
    i_sfs_host.write(sfs_pkg::ADDR_FAST_UV_FLAGS, 8'h3f);
    uv_exp = 6'h00;
    uv_en  = 6'h3e;
    below  = 6'h01;
    repeat (2) @(negedge clk);
    below = 6'h00;
    uv_en = 6'h3f;
    settle_check();
    below = 6'h04;
    repeat (2) @(negedge clk);
    below = 6'h00;
    rst   = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    settle_check();
    conclude();
  end
endmodule
